// >>> test/pcg_top_checker.sv
/*
  checker for pcg_top: apb answer, decode, reset state, enable follow, fault.
  assumes it is bound to pcg_top and sees only its ports.
*/
`timescale 1ns/1ps
module pcg_top_checker #(
  parameter int UNITS = 32
) (
  // apb
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // state and monitor
  input wire logic [1:0]       op_state,
  input wire logic             periph_req,
  input wire logic             periph_bank,
  input wire logic [4:0]       periph_unit,
  // enables and fault
  input wire logic [UNITS-1:0] clk_en_zero,
  input wire logic [UNITS-1:0] clk_en_one,
  input wire logic             periph_fault
);
  // --------
  // helpers
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc;
  wire logic gated;
  assign acc   = psel && penable && pready;
  assign gated = periph_bank ? !clk_en_one[periph_unit] : !clk_en_zero[periph_unit];

  // --------
  // properties
  // --------
  AST_APB_ANSWER:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle after setup");
  AST_UNMAPPED:
    assert property (acc && paddr == 12'h0FC |-> pslverr) else $error("unmapped access without error");
  AST_DEEP_MAPPED:
    assert property (acc && paddr == 12'h120 |-> !pslverr) else $error("deep set zero not decoded");
  AST_RUN1_MAPPED:
    assert property (acc && paddr == 12'h104 |-> !pslverr) else $error("run set one not decoded");
  AST_DEEP_RSVD:
    assert property (acc && !pwrite && paddr == 12'h120 |-> (prdata & 32'hFFFEFFB7) == 32'h00000000)
      else $error("reserved deep bits read nonzero");
  AST_RESET_OFF:
    assert property ($rose(presetn) |-> clk_en_zero == '0 && clk_en_one == '0) else $error("enables set at reset");
  AST_RUN_FOLLOW:
    assert property (acc && pwrite && paddr == 12'h100 && op_state == 2'b00 ##1 op_state == 2'b00
      |=> clk_en_zero == $past(pwdata, 2)) else $error("run enables do not follow write");
  AST_FAULT_SET:
    assert property (periph_req && gated |=> periph_fault) else $error("no fault on gated unit");
  AST_FAULT_CLR:
    assert property (!periph_req |=> !periph_fault) else $error("fault without access");
endmodule

bind pcg_top pcg_top_checker #(.UNITS(UNITS)) u_pcg_top_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_state(op_state),
  .periph_req(periph_req), .periph_bank(periph_bank), .periph_unit(periph_unit),
  .clk_en_zero(clk_en_zero), .clk_en_one(clk_en_one), .periph_fault(periph_fault));

// >>> test/testbench.sv
/*
  self-checking bench for pcg_top: register access over apb, enable
  selection per operating state, and fault flags.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module testbench;
  import pcg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        periph_req, periph_bank, periph_fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, clk_en_zero, clk_en_one, r;
  logic [1:0]  op_state;
  logic [4:0]  periph_unit;
  logic        e;
  int          bad_count, checks, cyc;

  pcg_top u_pcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_state(op_state), .periph_req(periph_req), .periph_bank(periph_bank), .periph_unit(periph_unit),
    .clk_en_zero(clk_en_zero), .clk_en_one(clk_en_one), .periph_fault(periph_fault));

  always #5 pclk = ~pclk;

  // --------
  // tasks
  // --------
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // entered just after a rising edge; returns one edge after the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed; only the bench timeout ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk("read data", r, exp);
  endtask

  // registered select: three edges after a write or state change
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic fault(input logic b, input logic [4:0] u, input logic exp);
    periph_req <= 1'b1; periph_bank <= b; periph_unit <= u;
    @(posedge pclk);
    periph_req <= 1'b0;
    @(posedge pclk);
    chk("fault", {31'h0, periph_fault}, {31'h0, exp});
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  // --------
  // sequence
  // --------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    op_state = PCG_ST_RUN; periph_req = 0; periph_bank = 0; periph_unit = '0;
    bad_count = 0; checks = 0; cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("en zero", clk_en_zero, 32'h00000000);
    rd(12'h100, 32'h00000000);
    rd(12'h104, 32'h00000000);
    rd(12'h120, 32'h00000040);
    apb(1'b1, 12'h120, 32'hFFFFFFFF);
    rd(12'h120, 32'h00010048);
    apb(1'b1, 12'h120, 32'h00000008);
    rd(12'h120, 32'h00000008);
    apb(1'b1, 12'h120, r | 32'h00010000);
    rd(12'h120, 32'h00010008);
    rd(12'h0FC, 32'h00000000);
    chk("slverr", {31'h0, e}, 32'h00000001);
    apb(1'b1, 12'h100, 32'h00000009);
    apb(1'b1, 12'h104, 32'h80000001);
    apb(1'b1, 12'h110, 32'h00000100);
    apb(1'b1, 12'h114, 32'h00000010);
    settle();
    chk("run zero", clk_en_zero, 32'h00000009);
    chk("run one", clk_en_one, 32'h80000001);
    fault(1'b0, 5'd3, 1'b0);
    fault(1'b0, 5'd1, 1'b1);
    fault(1'b1, 5'd31, 1'b0);
    fault(1'b1, 5'd1, 1'b1);
    rd(12'h1F0, 32'h00020011);
    apb(1'b1, 12'h1F0, 32'h00000001);
    rd(12'h1F0, 32'h00000000);
    op_state <= PCG_ST_DEEP;
    settle();
    chk("deep no auto", clk_en_zero, 32'h00000009);
    apb(1'b1, 12'h060, 32'h08000000);
    settle();
    chk("deep auto", clk_en_zero, 32'h00010008);
    chk("deep auto one", clk_en_one, 32'h00000000);
    rd(12'h1F0, 32'h0000080A);
    op_state <= PCG_ST_SLEEP;
    settle();
    chk("sleep auto", clk_en_zero, 32'h00000100);
    chk("sleep auto one", clk_en_one, 32'h00000010);
    op_state <= 2'b11;
    settle();
    chk("odd state", clk_en_zero, 32'h00000009);
    chk("odd state one", clk_en_one, 32'h80000001);
    rd(12'h1F0, 32'h0000100E);
    op_state <= PCG_ST_RUN;
    settle();
    chk("back to run", clk_en_zero, 32'h00000009);
    // second reset in mid-run: everything must return to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset en zero", clk_en_zero, 32'h00000000);
    chk("reset en one", clk_en_one, 32'h00000000);
    rd(12'h120, 32'h00000040);
    rd(12'h104, 32'h00000000);
    rd(12'h110, 32'h00000000);
    rd(12'h1F0, 32'h00000000);
    results();
  end
endmodule

// >>> verilog/pcg_pkg.sv
/*
  constants for the peripheral clock gating block: register offsets,
  field positions, reset values and operating-state codes.
  assumes a 32-bit apb register bus with byte addresses.
*/
package pcg_pkg;

  // ------------------------------------------------------------------
  // register offsets (byte addresses within the system-control space)
  // ------------------------------------------------------------------
  localparam logic [11:0] PCG_BASE_HI_NOTE        = 12'h000;
  localparam logic [11:0] PCG_OFF_RUN_GATE_ZERO   = 12'h100;
  localparam logic [11:0] PCG_OFF_RUN_GATE_ONE    = 12'h104;
  localparam logic [11:0] PCG_OFF_SLEEP_GATE_ZERO = 12'h110;
  localparam logic [11:0] PCG_OFF_SLEEP_GATE_ONE  = 12'h114;
  localparam logic [11:0] PCG_OFF_DEEP_GATE_ZERO  = 12'h120;
  localparam logic [11:0] PCG_OFF_DEEP_GATE_ONE   = 12'h124;
  localparam logic [11:0] PCG_OFF_RUN_CLOCK_CFG   = 12'h060;
  localparam logic [11:0] PCG_OFF_STATUS          = 12'h1F0;
  localparam logic [31:0] PCG_SYSCTL_BASE         = 32'h400FE000;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PCG_BIT_WATCHDOG  = 3;
  localparam int PCG_BIT_HIB       = 6;
  localparam int PCG_BIT_ADC       = 16;
  localparam int PCG_BIT_AUTO_GATE = 27;

  // ------------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] PCG_DEEP_ZERO_MASK  = 32'h00010048;
  localparam logic [31:0] PCG_DEEP_ZERO_RESET = 32'h00000040;
  localparam logic [31:0] PCG_GATE_RESET      = 32'h00000000;
  localparam logic [31:0] PCG_ALL_MASK        = 32'hFFFFFFFF;
  localparam logic [31:0] PCG_CFG_MASK        = 32'h08000000;
  localparam logic [31:0] PCG_CFG_RESET       = 32'h00000000;
  localparam logic [31:0] PCG_ZERO_WORD       = 32'h00000000;

  // ------------------------------------------------------------------
  // operating states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCG_ST_RUN   = 2'b00,
    PCG_ST_SLEEP = 2'b01,
    PCG_ST_DEEP  = 2'b10
  } pcg_state_e;

endpackage

// >>> verilog/pcg_reg.sv
/*
  one 32-bit gating register with a writable mask and a reset value.
  assumes the parent qualifies the write strobe with address decode.
*/
`timescale 1ns/1ps
module pcg_reg #(
  parameter logic [31:0] RESET_VAL = 32'h00000000,
  parameter logic [31:0] WR_MASK   = 32'hFFFFFFFF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // write port
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // stored value
  output logic      [31:0] value_q
);

  // read-only bits hold their reset value and ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RESET_VAL;
    end else if (wr_en) begin
      value_q <= (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

endmodule

// >>> verilog/pcg_select.sv
/*
  per-bit gate selection: picks the enable set of the current operating
  state when auto gating is on, else the run set, and registers it,
  so each enable changes only on a clock edge.
  assumes state and set inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
module pcg_select
  import pcg_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // selection
  input  wire logic [1:0]       state,
  input  wire logic             auto_gate,
  input  wire logic [WIDTH-1:0] run_set,
  input  wire logic [WIDTH-1:0] sleep_set,
  input  wire logic [WIDTH-1:0] deep_set,
  // registered enables
  output logic      [WIDTH-1:0] enable_q
);

  wire logic [WIDTH-1:0] sel_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic bit_d;
      always_comb begin
        bit_d = run_set[g];
        if (auto_gate) begin // see RULE7
          case (state)
            PCG_ST_SLEEP: bit_d = sleep_set[g];
            PCG_ST_DEEP:  bit_d = deep_set[g];
            default:      bit_d = run_set[g];
          endcase
        end
      end
      assign sel_d[g] = bit_d;
    end
  endgenerate

  // one flop process for the whole vector keeps enable_q single-driven
  // registered so the gate never glitches between sets, see RULE12
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= {WIDTH{1'b0}};
    end else begin
      enable_q <= sel_d;
    end
  end

endmodule

// >>> verilog/pcg_top.sv
/*
  peripheral clock gating control: run, sleep and deep-sleep gating
  register sets behind an apb slave, the registered per-unit clock
  enables, and bus-fault flags for accesses to gated-off units.
  assumes the power controller drives the operating state and that
  peripheral bus decode reports which unit a peripheral access targets.
*/
// What this block does
// RULE1: a set enable bit clocks its unit, a clear one leaves it unclocked and disabled.
// RULE2: an access to a unit whose clock is gated off is answered with a bus fault.
// RULE3: all gating enables reset to zero except bits documented otherwise.
// RULE4: the deep-sleep set zero resets to 0x00000040 with the hibernation enable set.
// RULE5: deep-sleep set zero bit 3 is a writable watchdog enable resetting to zero.
// RULE6: there are separate run, sleep and deep-sleep gating register sets.
// RULE7: sleep and deep-sleep sets apply only when auto gating is selected, else run.
// RULE8: deep-sleep set zero decodes at offset 0x120 from the system-control base.
// RULE9: run set one decodes at offset 0x104 and resets to all zeros.
// RULE10: software keeps reserved bits across read-modify-write and ignores their value.
// RULE11: deep-sleep set zero bit 16 is a writable converter enable; other reserved bits read zero.
// RULE12: on a state change each enable moves to the new set glitch-free on a clock edge.
`timescale 1ns/1ps
module pcg_top
  import pcg_pkg::*;
#(
  parameter int UNITS = 32
) (
  // apb clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // operating state from the power controller
  input  wire logic [1:0]       op_state,
  // peripheral access monitor
  input  wire logic             periph_req,
  input  wire logic             periph_bank,
  input  wire logic [4:0]       periph_unit,
  // per-unit clock enables and bus fault
  output logic      [UNITS-1:0] clk_en_zero,
  output logic      [UNITS-1:0] clk_en_one,
  output logic                  periph_fault
);

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic        setup_q;
  logic        access;
  logic        wr;
  logic        hit_run0;
  logic        hit_run1;
  logic        hit_slp0;
  logic        hit_slp1;
  logic        hit_dsl0;
  logic        hit_dsl1;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_any;

  // no wait state: setup is seen, then access completes with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q <= 1'b0;
    end else begin
      setup_q <= psel & ~penable;
    end
  end

  assign access   = psel & penable & setup_q;
  assign wr       = access & pwrite;
  assign hit_run0 = (paddr == PCG_OFF_RUN_GATE_ZERO);
  assign hit_run1 = (paddr == PCG_OFF_RUN_GATE_ONE);   // see RULE9
  assign hit_slp0 = (paddr == PCG_OFF_SLEEP_GATE_ZERO);
  assign hit_slp1 = (paddr == PCG_OFF_SLEEP_GATE_ONE);
  assign hit_dsl0 = (paddr == PCG_OFF_DEEP_GATE_ZERO); // see RULE8
  assign hit_dsl1 = (paddr == PCG_OFF_DEEP_GATE_ONE);
  assign hit_cfg  = (paddr == PCG_OFF_RUN_CLOCK_CFG);
  assign hit_stat = (paddr == PCG_OFF_STATUS);
  assign hit_any  = hit_run0 | hit_run1 | hit_slp0 | hit_slp1 |
                    hit_dsl0 | hit_dsl1 | hit_cfg | hit_stat;

  // ------------------------------------------------------------------
  // gating register sets
  // ------------------------------------------------------------------
  logic [31:0] run0_q;
  logic [31:0] run1_q;
  logic [31:0] slp0_q;
  logic [31:0] slp1_q;
  logic [31:0] dsl0_q;
  logic [31:0] dsl1_q;
  logic [31:0] cfg_q;

  // three independent sets, see RULE6; all-zero resets, see RULE3
  pcg_reg #(.RESET_VAL(PCG_GATE_RESET), .WR_MASK(PCG_ALL_MASK)) u_run0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_run0),
    .wr_data (pwdata),
    .value_q (run0_q)
  );

  pcg_reg #(.RESET_VAL(PCG_GATE_RESET), .WR_MASK(PCG_ALL_MASK)) u_run1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_run1),
    .wr_data (pwdata),
    .value_q (run1_q)
  );

  pcg_reg #(.RESET_VAL(PCG_GATE_RESET), .WR_MASK(PCG_ALL_MASK)) u_slp0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_slp0),
    .wr_data (pwdata),
    .value_q (slp0_q)
  );

  pcg_reg #(.RESET_VAL(PCG_GATE_RESET), .WR_MASK(PCG_ALL_MASK)) u_slp1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_slp1),
    .wr_data (pwdata),
    .value_q (slp1_q)
  );

  // only watchdog, hibernation and converter bits are writable,
  // see RULE4, see RULE5, see RULE11
  pcg_reg #(.RESET_VAL(PCG_DEEP_ZERO_RESET), .WR_MASK(PCG_DEEP_ZERO_MASK)) u_dsl0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_dsl0),
    .wr_data (pwdata),
    .value_q (dsl0_q)
  );

  pcg_reg #(.RESET_VAL(PCG_GATE_RESET), .WR_MASK(PCG_ALL_MASK)) u_dsl1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_dsl1),
    .wr_data (pwdata),
    .value_q (dsl1_q)
  );

  // run clock config: only the auto gating select bit is kept
  pcg_reg #(.RESET_VAL(PCG_CFG_RESET), .WR_MASK(PCG_CFG_MASK)) u_cfg (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr & hit_cfg),
    .wr_data (pwdata),
    .value_q (cfg_q)
  );

  logic auto_gating_select;
  assign auto_gating_select = cfg_q[PCG_BIT_AUTO_GATE];

  // ------------------------------------------------------------------
  // enable selection per operating state
  // ------------------------------------------------------------------
  logic [UNITS-1:0] en0_q;
  logic [UNITS-1:0] en1_q;

  // set bit clocks the unit, clear bit leaves it disabled, see RULE1
  pcg_select #(.WIDTH(UNITS)) u_sel0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .state     (op_state),
    .auto_gate (auto_gating_select),
    .run_set   (run0_q[UNITS-1:0]),
    .sleep_set (slp0_q[UNITS-1:0]),
    .deep_set  (dsl0_q[UNITS-1:0]),
    .enable_q  (en0_q)
  );

  pcg_select #(.WIDTH(UNITS)) u_sel1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .state     (op_state),
    .auto_gate (auto_gating_select),
    .run_set   (run1_q[UNITS-1:0]),
    .sleep_set (slp1_q[UNITS-1:0]),
    .deep_set  (dsl1_q[UNITS-1:0]),
    .enable_q  (en1_q)
  );

  assign clk_en_zero = en0_q;
  assign clk_en_one  = en1_q;

  // ------------------------------------------------------------------
  // bus fault on access to a gated-off unit
  // ------------------------------------------------------------------
  logic unit_on;
  logic fault_sticky_q;

  assign unit_on = periph_bank ? en1_q[periph_unit] : en0_q[periph_unit];

  // pulse in the cycle after the offending request, see RULE2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_fault <= 1'b0;
    end else begin
      periph_fault <= periph_req & ~unit_on;
    end
  end

  // sticky record; a new fault wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_sticky_q <= 1'b0;
    end else if (periph_req & ~unit_on) begin
      fault_sticky_q <= 1'b1;
    end else if (wr & hit_stat & pwdata[0]) begin
      fault_sticky_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // fault capture
  // ------------------------------------------------------------------
  logic       fault_hit;
  logic       fault_clr;
  logic [4:0] fault_unit_q;
  logic       fault_bank_q;
  logic [1:0] fault_state_q;

  assign fault_hit = periph_req & ~unit_on;
  assign fault_clr = wr & hit_stat & pwdata[0];

  // keeps the first offender only, so the root cause is not overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_unit_q  <= 5'h00;
      fault_bank_q  <= 1'b0;
      fault_state_q <= 2'h0;
    end else if (fault_hit & (~fault_sticky_q | fault_clr)) begin
      fault_unit_q  <= periph_unit;
      fault_bank_q  <= periph_bank;
      fault_state_q <= op_state;
    end else if (fault_clr) begin
      fault_unit_q  <= 5'h00;
      fault_bank_q  <= 1'b0;
      fault_state_q <= 2'h0;
    end
  end

  // ------------------------------------------------------------------
  // fault count
  // ------------------------------------------------------------------
  logic [7:0] fault_cnt_q;

  // saturates instead of wrapping, so a flood never reads as quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_cnt_q <= 8'h00;
    end else if (fault_clr) begin
      fault_cnt_q <= {7'h00, fault_hit};
    end else if (fault_hit && (fault_cnt_q != 8'hFF)) begin
      fault_cnt_q <= fault_cnt_q + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // applied set indicator
  // ------------------------------------------------------------------
  pcg_state_e applied_d;
  pcg_state_e applied_q;

  // manual gating and state code 3 both fall back to the run set, see RULE7
  always_comb begin
    applied_d = PCG_ST_RUN;
    if (auto_gating_select) begin
      case (op_state)
        PCG_ST_SLEEP: applied_d = PCG_ST_SLEEP;
        PCG_ST_DEEP:  applied_d = PCG_ST_DEEP;
        default:      applied_d = PCG_ST_RUN;
      endcase
    end
  end

  // registered like the enables, so both move on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_q <= PCG_ST_RUN;
    end else begin
      applied_q <= applied_d;
    end
  end

  // ------------------------------------------------------------------
  // undefined state check
  // ------------------------------------------------------------------
  logic odd_state_q;

  // state code 3 has no set of its own; remember that it was seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_state_q <= 1'b0;
    end else if (op_state == 2'b11) begin
      odd_state_q <= 1'b1;
    end else if (fault_clr) begin
      odd_state_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // apb response
  // ------------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb begin
    rd_d = PCG_ZERO_WORD;
    if (hit_run0) rd_d = run0_q;
    if (hit_run1) rd_d = run1_q;
    if (hit_slp0) rd_d = slp0_q;
    if (hit_slp1) rd_d = slp1_q;
    if (hit_dsl0) rd_d = dsl0_q;
    if (hit_dsl1) rd_d = dsl1_q;
    if (hit_cfg)  rd_d = cfg_q;
    if (hit_stat) begin
      rd_d = {8'h00, fault_cnt_q, 1'b0, fault_state_q, odd_state_q, applied_q, fault_bank_q,
              fault_unit_q, op_state, auto_gating_select, fault_sticky_q};
    end
  end

  // outputs registered: answer shows in the access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= PCG_ZERO_WORD;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_d : PCG_ZERO_WORD;
    end
  end

endmodule
